// File: common/i2c_slave_pkg.sv
/*
 Constants, enumerations and carrier types of the serial port slave engine.
 Assumes a core clock and a separate link clock that samples the bus pins.
*/
// Functional notes
// - Read address match sets rw status, transmits.
// - Read match: acknowledge, then stretch SCL low.
// - Buffer write by software sets full flag.
// - Transmit-stretched SCL released only by release bit.
// - Transmit raises interrupt flag once per byte.
// - Full clears at 8th fall, flag 9th.
// - SDA released after eighth falling SCL edge.
// - Master not-acknowledge ends transmit, await Start.
// - Master acknowledge stretches SCL again until release.
// - Auto stretch after 10-bit address, hardware clear.
// - Hardware-cleared release bit keeps SCL low.
// - 10-bit: hold until address write, flag update.
// - Start/Stop seen cleared on reset/disable, tracked.
// - Firmware master pins drive low only.
// - Firmware master: interrupt on Start, Stop, byte.
// - Firmware master in mode 1011 only; Start/Stop modes are slave.
// - Busy bus: interrupt raised at Stop.
// - Slave keeps receiving after lost arbitration.
// - Sleep: address match or byte wakes processor.
// - Drive SCL low only after sampling it low.
// - Release SCL after release bit set.
// - 7-bit address compared at eighth falling edge.
// - Full or overflow: no ack, no load, flag.
package i2c_slave_pkg;
  localparam logic [3:0] MODE_SLAVE7 = 4'h6;
  localparam logic [3:0] MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] MODE_FW_MASTER = 4'hb;
  localparam logic [3:0] MODE_SLAVE7_SP = 4'he;
  localparam logic [3:0] MODE_SLAVE10_SP = 4'hf;
  localparam logic [3:0] LAST_BIT = 4'h8;
  localparam logic [3:0] CNT_RST = 4'h0;
  localparam logic [4:0] TEN_BIT_HDR = 5'h1e;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] BYTE_RST = 8'h00;

  typedef enum logic [2:0] {
    st_idle, st_addr, st_data, st_ack, st_tx, st_txack
  } phase_type;

  typedef struct packed {
    logic buf_wr;
    logic buf_rd;
    logic rel_set;
    logic addr_wr;
    logic irq_clr;
    logic ov_clr;
  } sw_req_type;

  typedef struct packed {
    logic sda_dir;
    logic scl_dir;
    logic [3:0] mode;
    logic en;
  } level_type;

  typedef struct packed {
    logic buffer_full_flag;
    logic overflow_flag;
    logic clock_release_bit;
    logic port_irq_flag;
    logic addr_update_flag;
    logic rw_status;
    logic data_not_addr;
    logic start_seen;
    logic stop_seen;
  } port_status_type;
endpackage

// File: design/i2c_slave_engine.sv
/*
 Slave engine of the synchronous serial port: receive, transmit with
 clock stretching, Start/Stop tracking and firmware master pin drive.
 Assumes open-drain pins with external pull-ups resolved outside, and a
 link clock much faster than SCL that samples the pins.
*/
`timescale 1ns/1ns
module i2c_slave_engine
  import i2c_slave_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe,
  output logic sda_out,
  output logic sda_oe,
  input wire logic port_enable_bit,
  input wire logic [3:0] port_mode_field,
  input wire logic scl_pin_direction_bit,
  input wire logic sda_pin_direction_bit,
  input wire logic irq_enable,
  input wire sw_req_type sw_req,
  input wire logic [7:0] buf_wdata,
  input wire logic [7:0] addr_wdata,
  output logic [7:0] xfer_buffer,
  output port_status_type port_status_reg,
  output logic wake_req
);

  typedef struct packed {
    logic scl_m;
    logic scl_s;
    logic scl_p;
    logic sda_m;
    logic sda_s;
    logic sda_p;
    logic [5:0] ev_m;
    logic [5:0] ev_s;
    logic [5:0] ev_p;
    level_type lv_m;
    level_type lv_s;
    phase_type ph;
    logic [3:0] cnt;
    logic [7:0] shift;
    logic [7:0] rx_buf;
    logic rx_tog;
    logic [7:0] txbuf;
    logic [7:0] own;
    port_status_type st;
    logic drv;
    logic rd;
    logic upd;
    logic nack;
    logic hold;
    logic ten_hi;
    logic ten_ok;
    logic scl_drv;
    logic sda_drv;
  } link_state_type;

  typedef struct packed {
    logic [5:0] ev_tog;
    logic [7:0] wdata;
    logic [7:0] awdata;
    logic rxt_m;
    logic rxt_s;
    logic rxt_p;
    logic [7:0] rx_data;
    port_status_type st_m;
    port_status_type st_s;
  } host_state_type;

  link_state_type l_ff;
  link_state_type nxt_l;
  host_state_type h_ff;
  host_state_type nxt_h;
  sw_req_type ev;
  logic rise;
  logic fall;
  logic start_cond;
  logic stop_cond;
  logic fw;
  logic slave;
  logic ten;
  logic sp_irq;
  logic match;
  logic ua_hold;

  // Core clock side: requests become toggles, status is resynchronised.
  always_comb begin
    nxt_h = h_ff;
    nxt_h.ev_tog = h_ff.ev_tog ^ sw_req;
    if (sw_req.buf_wr) begin
      nxt_h.wdata = buf_wdata;
    end
    if (sw_req.addr_wr) begin
      nxt_h.awdata = addr_wdata;
    end
    nxt_h.rxt_m = l_ff.rx_tog;
    nxt_h.rxt_s = h_ff.rxt_m;
    nxt_h.rxt_p = h_ff.rxt_s;
    // The received byte stays put for a whole byte time after its toggle.
    if (h_ff.rxt_s != h_ff.rxt_p) begin
      nxt_h.rx_data = l_ff.rx_buf;
    end
    nxt_h.st_m = l_ff.st;
    nxt_h.st_s = h_ff.st_m;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      h_ff <= '0;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign xfer_buffer = h_ff.rx_data;
  assign port_status_reg = h_ff.st_s;
  assign wake_req = h_ff.st_s.port_irq_flag & irq_enable;

  // Link side decode.
  assign ev = sw_req_type'(l_ff.ev_s ^ l_ff.ev_p);
  assign rise = l_ff.scl_s & ~l_ff.scl_p;
  assign fall = ~l_ff.scl_s & l_ff.scl_p;
  assign start_cond = l_ff.scl_s & l_ff.scl_p & l_ff.sda_p & ~l_ff.sda_s;
  assign stop_cond = l_ff.scl_s & l_ff.scl_p & ~l_ff.sda_p & l_ff.sda_s;
  assign fw = l_ff.lv_s.mode == MODE_FW_MASTER;
  assign slave = l_ff.lv_s.mode == MODE_SLAVE7 ||
                 l_ff.lv_s.mode == MODE_SLAVE10 ||
                 l_ff.lv_s.mode == MODE_SLAVE7_SP ||
                 l_ff.lv_s.mode == MODE_SLAVE10_SP;
  assign ten = slave & l_ff.lv_s.mode[0];
  assign sp_irq = fw || l_ff.lv_s.mode == MODE_SLAVE7_SP ||
                  l_ff.lv_s.mode == MODE_SLAVE10_SP;
  assign ua_hold = ten & l_ff.st.addr_update_flag;

  always_comb begin
    match = l_ff.shift[7:1] == l_ff.own[7:1];
    if (ten) begin
      if (l_ff.ten_hi) begin
        match = l_ff.shift == l_ff.own;
      end else begin
        match = match && l_ff.shift[7:3] == TEN_BIT_HDR &&
                (!l_ff.shift[0] || l_ff.ten_ok);
      end
    end
  end

  always_comb begin
    nxt_l = l_ff;
    nxt_l.scl_m = scl_in;
    nxt_l.scl_s = l_ff.scl_m;
    nxt_l.scl_p = l_ff.scl_s;
    nxt_l.sda_m = sda_in;
    nxt_l.sda_s = l_ff.sda_m;
    nxt_l.sda_p = l_ff.sda_s;
    nxt_l.ev_m = h_ff.ev_tog;
    nxt_l.ev_s = l_ff.ev_m;
    nxt_l.ev_p = l_ff.ev_s;
    nxt_l.lv_m = '{sda_dir: sda_pin_direction_bit,
                   scl_dir: scl_pin_direction_bit,
                   mode: port_mode_field, en: port_enable_bit};
    nxt_l.lv_s = l_ff.lv_m;
    // Software actions first, so that bus events below win over clears.
    if (ev.buf_wr) begin
      nxt_l.txbuf = h_ff.wdata;
      nxt_l.st.buffer_full_flag = 1'b1;
    end
    if (ev.buf_rd) begin
      nxt_l.st.buffer_full_flag = 1'b0;
    end
    if (ev.rel_set) begin
      nxt_l.st.clock_release_bit = 1'b1;
      nxt_l.hold = 1'b0;
      if (l_ff.ph == st_tx && l_ff.cnt == CNT_RST) begin
        nxt_l.shift = nxt_l.txbuf;
      end
    end
    if (ev.addr_wr) begin
      nxt_l.own = h_ff.awdata;
      nxt_l.st.addr_update_flag = 1'b0;
    end
    if (ev.irq_clr) begin
      nxt_l.st.port_irq_flag = 1'b0;
    end
    if (ev.ov_clr) begin
      nxt_l.st.overflow_flag = 1'b0;
    end
    if (start_cond) begin
      nxt_l.st.start_seen = 1'b1;
      nxt_l.st.stop_seen = 1'b0;
      if (sp_irq) begin
        nxt_l.st.port_irq_flag = 1'b1;
      end
      nxt_l.ph = (slave || fw) ? st_addr : st_idle;
      nxt_l.cnt = CNT_RST;
      nxt_l.drv = 1'b0;
      nxt_l.hold = 1'b0;
    end else if (stop_cond) begin
      nxt_l.st.stop_seen = 1'b1;
      nxt_l.st.start_seen = 1'b0;
      if (sp_irq) begin
        nxt_l.st.port_irq_flag = 1'b1;
      end
      nxt_l.ph = st_idle;
      nxt_l.ten_ok = 1'b0;
      nxt_l.ten_hi = 1'b0;
      nxt_l.drv = 1'b0;
      nxt_l.st.rw_status = 1'b0;
    end else begin
      case (l_ff.ph)
        st_addr, st_data: begin
          // Receiving continues whatever the firmware master did.
          if (rise) begin
            nxt_l.shift = {l_ff.shift[6:0], l_ff.sda_s};
            nxt_l.cnt = l_ff.cnt + 4'h1;
          end
          if (fall && l_ff.cnt == LAST_BIT) begin
            nxt_l.ph = st_ack;
            nxt_l.cnt = CNT_RST;
            nxt_l.drv = 1'b0;
            nxt_l.rd = 1'b0;
            nxt_l.upd = 1'b0;
            if (fw) begin
              nxt_l.ph = st_ack;
            end else if (l_ff.ph == st_data || match) begin
              nxt_l.st.data_not_addr = l_ff.ph == st_data;
              // The low byte of a 10-bit address carries no read bit.
              if (l_ff.ph == st_addr && l_ff.shift[0] &&
                  !(ten && l_ff.ten_hi)) begin
                nxt_l.st.rw_status = 1'b1;
                nxt_l.drv = 1'b1;
                nxt_l.rd = 1'b1;
              end else if (l_ff.st.buffer_full_flag ||
                           l_ff.st.overflow_flag) begin
                nxt_l.st.overflow_flag = 1'b1;
              end else begin
                nxt_l.rx_buf = l_ff.shift;
                nxt_l.rx_tog = ~l_ff.rx_tog;
                nxt_l.st.buffer_full_flag = 1'b1;
                nxt_l.st.rw_status = 1'b0;
                nxt_l.drv = 1'b1;
              end
              if (ten && l_ff.ph == st_addr &&
                  (l_ff.ten_hi || !l_ff.shift[0])) begin
                nxt_l.upd = 1'b1;
                nxt_l.ten_ok = l_ff.ten_hi;
                nxt_l.ten_hi = ~l_ff.ten_hi;
              end
            end else begin
              nxt_l.ph = st_idle;
            end
          end
        end
        st_ack: begin
          if (fall) begin
            nxt_l.st.port_irq_flag = 1'b1;
            nxt_l.drv = 1'b0;
            nxt_l.st.addr_update_flag = l_ff.upd |
                                        l_ff.st.addr_update_flag;
            nxt_l.upd = 1'b0;
            if (l_ff.rd) begin
              nxt_l.st.clock_release_bit = 1'b0;
              nxt_l.hold = 1'b1;
              nxt_l.ph = st_tx;
            end else begin
              // After the high byte the low address byte still follows.
              nxt_l.ph = (l_ff.upd && l_ff.ten_hi) ? st_addr : st_data;
            end
          end
        end
        st_tx: begin
          if (rise && l_ff.st.clock_release_bit) begin
            nxt_l.cnt = l_ff.cnt + 4'h1;
          end
          if (fall && l_ff.cnt != CNT_RST) begin
            if (l_ff.cnt == LAST_BIT) begin
              nxt_l.st.buffer_full_flag = 1'b0;
              nxt_l.ph = st_txack;
            end else begin
              nxt_l.shift = {l_ff.shift[6:0], 1'b0};
            end
          end
        end
        st_txack: begin
          if (rise) begin
            nxt_l.nack = l_ff.sda_s;
          end
          if (fall) begin
            nxt_l.st.port_irq_flag = 1'b1;
            nxt_l.cnt = CNT_RST;
            if (l_ff.nack) begin
              nxt_l.ph = st_idle;
              nxt_l.st.rw_status = 1'b0;
            end else begin
              nxt_l.st.clock_release_bit = 1'b0;
              nxt_l.hold = 1'b1;
              nxt_l.ph = st_tx;
            end
          end
        end
        default: begin
          nxt_l.ph = st_idle;
        end
      endcase
    end
    // A hardware hold only grabs SCL once the line is seen low.
    nxt_l.scl_drv = (l_ff.hold | ua_hold) &
                    (l_ff.scl_drv | ~l_ff.scl_s);
    // The last bit stays on SDA until the eighth fall; dropping it at the
    // eighth rise would make a false Stop while SCL is high.
    nxt_l.sda_drv = (nxt_l.ph == st_ack && nxt_l.drv) ||
                    (nxt_l.ph == st_tx && nxt_l.st.clock_release_bit &&
                     !nxt_l.shift[7]);
    if (!l_ff.lv_s.en) begin
      nxt_l.st = '0;
      nxt_l.ph = st_idle;
      nxt_l.drv = 1'b0;
      nxt_l.hold = 1'b0;
      nxt_l.ten_hi = 1'b0;
      nxt_l.ten_ok = 1'b0;
      nxt_l.scl_drv = 1'b0;
      nxt_l.sda_drv = 1'b0;
    end
  end

  always_ff @(posedge link_clk or negedge rst_b) begin
    if (!rst_b) begin
      l_ff <= '0;
    end else begin
      l_ff <= nxt_l;
    end
  end

  // Pins only ever pull low; firmware bit-banging uses the direction
  // bits, and it alone must watch for lost arbitration.
  assign scl_out = 1'b0;
  assign sda_out = 1'b0;
  assign scl_oe = l_ff.scl_drv |
                  (l_ff.lv_s.en & ~l_ff.lv_s.scl_dir);
  assign sda_oe = l_ff.sda_drv |
                  (l_ff.lv_s.en & ~l_ff.lv_s.sda_dir);

  default clocking cb @(posedge link_clk);
  endclocking
  default disable iff (!rst_b);

  property p_grab_low;
    $rose(l_ff.scl_drv) |-> $past(!l_ff.scl_s);
  endproperty
  a_grab_low: assert property (p_grab_low)
    else $error("SCL pulled low while it was high.");

  property p_release;
    (ev.rel_set && !ua_hold && !start_cond && !stop_cond &&
     l_ff.lv_s.en) |=> ##1 !l_ff.scl_drv;
  endproperty
  a_release: assert property (p_release)
    else $error("SCL still held after release bit set.");

  property p_bf_clear;
    (l_ff.lv_s.en && l_ff.ph == st_tx && fall && l_ff.cnt == LAST_BIT &&
     !start_cond && !stop_cond) |=> !l_ff.st.buffer_full_flag &&
     l_ff.ph == st_txack;
  endproperty
  a_bf_clear: assert property (p_bf_clear)
    else $error("Full flag not cleared at eighth fall.");

  property p_irq_ninth;
    (l_ff.lv_s.en && l_ff.ph == st_txack && fall && !stop_cond &&
     !start_cond) |=> l_ff.st.port_irq_flag;
  endproperty
  a_irq_ninth: assert property (p_irq_ninth)
    else $error("Interrupt flag not set at ninth fall.");

  property p_sda_free;
    (l_ff.ph == st_txack && $past(l_ff.ph) == st_txack) |->
      !l_ff.sda_drv;
  endproperty
  a_sda_free: assert property (p_sda_free)
    else $error("SDA driven during master acknowledge.");

  property p_nack_end;
    (l_ff.lv_s.en && l_ff.ph == st_txack && fall && l_ff.nack &&
     !start_cond) |=> l_ff.ph == st_idle;
  endproperty
  a_nack_end: assert property (p_nack_end)
    else $error("Transmit not ended after not-acknowledge.");

  property p_ack_stretch;
    (l_ff.lv_s.en && l_ff.ph == st_txack && fall && !l_ff.nack &&
     !start_cond && !stop_cond) |=> !l_ff.st.clock_release_bit &&
     l_ff.hold ##1 l_ff.scl_drv;
  endproperty
  a_ack_stretch: assert property (p_ack_stretch)
    else $error("No stretch after master acknowledge.");

  property p_disable_clr;
    !l_ff.lv_s.en |=> !l_ff.st.start_seen && !l_ff.st.stop_seen;
  endproperty
  a_disable_clr: assert property (p_disable_clr)
    else $error("Start or Stop seen survived disable.");

  property p_rd_status;
    (l_ff.ph == st_ack && l_ff.rd) |-> l_ff.st.rw_status;
  endproperty
  a_rd_status: assert property (p_rd_status)
    else $error("Read match without rw status.");

  property p_full_refuse;
    (l_ff.lv_s.en && l_ff.ph == st_data && fall && l_ff.cnt == LAST_BIT &&
     (l_ff.st.buffer_full_flag || l_ff.st.overflow_flag) &&
     !start_cond && !stop_cond) |=> !l_ff.drv && $stable(l_ff.rx_buf);
  endproperty
  a_full_refuse: assert property (p_full_refuse)
    else $error("Byte taken while buffer full.");

  property p_sda_scl_low;
    (l_ff.ph == st_tx && $changed(l_ff.sda_drv)) |-> !l_ff.scl_s;
  endproperty
  a_sda_scl_low: assert property (p_sda_scl_low)
    else $error("SDA changed while SCL high.");

  property p_wr_full;
    (ev.buf_wr && l_ff.lv_s.en && !(l_ff.ph == st_tx && fall)) |=>
      l_ff.st.buffer_full_flag;
  endproperty
  a_wr_full: assert property (p_wr_full)
    else $error("Buffer write did not set full flag.");

  property p_c_read;
    l_ff.ph == st_txack ##1 l_ff.ph == st_tx;
  endproperty
  c_read: cover property (p_c_read);

  property p_c_nack;
    l_ff.ph == st_txack ##1 l_ff.ph == st_idle;
  endproperty
  c_nack: cover property (p_c_nack);

  property p_c_ua;
    $rose(l_ff.st.addr_update_flag);
  endproperty
  c_ua: cover property (p_c_ua);

  property p_c_ovf;
    $rose(l_ff.st.overflow_flag);
  endproperty
  c_ovf: cover property (p_c_ovf);

endmodule

// File: tb/i2c_master_model.sv
/*
 Behavioural bus master that drives the far side of the slave engine.
 Assumes pull-ups on both lines; the wired levels arrive on scl_in, sda_in.
*/
`timescale 1ns/1ns
module i2c_master_model (
  input wire logic link_clk,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_oe,
  output logic sda_oe
);
  int timeouts = 0;
  initial begin
    scl_oe = 1'b0;
    sda_oe = 1'b0;
  end
  task automatic half();
    repeat (4) @(negedge link_clk);
  endtask
  // The slave may stretch, so the high time counts only once SCL is high.
  task automatic scl_high();
    int n;
    n = 0;
    scl_oe = 1'b0;
    while (scl_in !== 1'b1 && n < 4000) begin
      @(negedge link_clk);
      n++;
    end
    if (n >= 4000) timeouts++;
    half();
  endtask
  task automatic start();
    sda_oe = 1'b0;
    half();
    scl_high();
    sda_oe = 1'b1;
    half();
    scl_oe = 1'b1;
    half();
  endtask
  task automatic stop();
    sda_oe = 1'b1;
    half();
    scl_high();
    sda_oe = 1'b0;
    half();
  endtask
  // Data changes only while this model itself holds SCL low.
  task automatic bit_io(input logic b, output logic r);
    sda_oe = ~b;
    half();
    scl_high();
    r = sda_in;
    scl_oe = 1'b1;
    half();
  endtask
  task automatic byte_io(input logic [7:0] d, input logic last,
                         output logic [7:0] r, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(last, a);
    ack = ~a;
    // Drop an acknowledge drive while SCL is still low.
    sda_oe = 1'b0;
  endtask
  task automatic let_go();
    scl_oe = 1'b0;
  endtask
  task automatic set_lines(input logic c, input logic d);
    scl_oe = c;
    sda_oe = d;
  endtask
endmodule

// File: tb/i2c_slave_engine_tb.sv
/*
 Self-checking bench of the slave engine against a queue model.
 Assumes the engine, its package and the master model are compiled first.
*/
`timescale 1ns/1ns
module i2c_slave_engine_tb;
  import i2c_slave_pkg::*;
  logic clk, rst_b, link_clk, en, scl_dir, sda_dir, irq_en;
  logic [3:0] mode;
  sw_req_type sw_req;
  logic [7:0] buf_wdata, addr_wdata, xfer_buffer, rd;
  port_status_type st;
  logic scl_oe, sda_oe, m_scl_oe, m_sda_oe, scl_in, sda_in, wake_req, ack;
  int failures = 0;
  int checked = 0;
  int seed = 32'h3942;
  logic [7:0] txq[$];
  assign scl_in = ~(scl_oe | m_scl_oe);
  assign sda_in = ~(sda_oe | m_sda_oe);
  i2c_slave_engine i2c_slave_engine_inst (.clk(clk), .rst_b(rst_b),
    .link_clk(link_clk), .scl_in(scl_in), .sda_in(sda_in), .scl_out(),
    .scl_oe(scl_oe), .sda_out(), .sda_oe(sda_oe), .port_enable_bit(en),
    .port_mode_field(mode), .scl_pin_direction_bit(scl_dir),
    .sda_pin_direction_bit(sda_dir), .irq_enable(irq_en), .sw_req(sw_req),
    .buf_wdata(buf_wdata), .addr_wdata(addr_wdata),
    .xfer_buffer(xfer_buffer), .port_status_reg(st), .wake_req(wake_req));
  i2c_master_model i2c_master_model_inst (.link_clk(link_clk),
    .scl_in(scl_in), .sda_in(sda_in), .scl_oe(m_scl_oe), .sda_oe(m_sda_oe));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // The link clock starts off phase so that no edges line up.
  initial begin
    link_clk = 1'b0;
    #3;
    forever #16 link_clk = ~link_clk;
  end
  task automatic chk(input string name, input logic [7:0] exp,
                     input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
      failures++;
    end
  endtask
  task automatic settle();
    repeat (60) @(negedge clk);
  endtask
  // Pulses are spaced well beyond four link periods by the settle wait.
  task automatic pulse(input sw_req_type r);
    @(negedge clk);
    sw_req = r;
    @(negedge clk);
    sw_req = '0;
    settle();
  endtask
  task automatic print_verdict();
    failures += i2c_master_model_inst.timeouts;
    $display("comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic stretch_seen();
    i2c_master_model_inst.let_go();
    settle();
    chk("scl held", 8'h00, {7'h00, scl_in});
  endtask
  initial begin
    #350000;
    failures++;
    print_verdict();
  end
  initial begin
    rst_b = 1'b0;
    en = 1'b0;
    mode = MODE_SLAVE7;
    scl_dir = 1'b1;
    sda_dir = 1'b1;
    irq_en = 1'b1;
    sw_req = '0;
    buf_wdata = 8'h00;
    addr_wdata = 8'ha4;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    settle();
    chk("status", 8'h00, st[7:0]);
    chk("oe", 8'h00, {6'h00, scl_oe, sda_oe});
    en = 1'b1;
    settle();
    pulse('{addr_wr: 1'b1, default: 1'b0});
    i2c_master_model_inst.start();
    settle();
    chk("start_seen", 8'h01, {7'h00, st.start_seen});
    i2c_master_model_inst.byte_io(8'ha4, 1'b1, rd, ack);
    chk("write addr ack", 8'h01, {7'h00, ack});
    pulse('{buf_rd: 1'b1, irq_clr: 1'b1, default: 1'b0});
    buf_wdata = 8'($random(seed));
    i2c_master_model_inst.byte_io(buf_wdata, 1'b1, rd, ack);
    settle();
    chk("data ack", 8'h01, {7'h00, ack});
    chk("received", buf_wdata, xfer_buffer);
    pulse('{irq_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.byte_io(~buf_wdata, 1'b1, rd, ack);
    settle();
    chk("full ack", 8'h00, {7'h00, ack});
    chk("kept", buf_wdata, xfer_buffer);
    chk("ov irq", 8'h03, {6'h00, st.overflow_flag, st.port_irq_flag});
    pulse('{buf_rd: 1'b1, irq_clr: 1'b1, ov_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.stop();
    settle();
    chk("stop", 8'h01, {6'h00, st.start_seen, st.stop_seen});
    i2c_master_model_inst.start();
    i2c_master_model_inst.byte_io(8'h21, 1'b1, rd, ack);
    chk("foreign ack", 8'h00, {7'h00, ack});
    i2c_master_model_inst.start();
    i2c_master_model_inst.byte_io(8'ha5, 1'b1, rd, ack);
    chk("read addr ack", 8'h01, {7'h00, ack});
    settle();
    chk("rw irq rel", 8'h06, {5'h00, st.rw_status, st.port_irq_flag,
        st.clock_release_bit});
    chk("wake", 8'h01, {7'h00, wake_req});
    irq_en = 1'b0;
    settle();
    chk("wake off", 8'h00, {7'h00, wake_req});
    irq_en = 1'b1;
    stretch_seen();
    for (int k = 0; k < 2; k++) begin
      buf_wdata = 8'($random(seed));
      txq.push_back(buf_wdata);
      pulse('{buf_wr: 1'b1, irq_clr: 1'b1, default: 1'b0});
      chk("bf set", 8'h01, {7'h00, st.buffer_full_flag});
      chk("irq clr", 8'h00, {7'h00, st.port_irq_flag});
      chk("still held", 8'h00, {7'h00, scl_in});
      pulse('{rel_set: 1'b1, default: 1'b0});
      i2c_master_model_inst.byte_io(8'hff, k == 1, rd, ack);
      chk("sent", txq.pop_front(), rd);
      settle();
      chk("bf irq", 8'h01, {6'h00, st.buffer_full_flag,
          st.port_irq_flag});
      if (k == 0) begin
        chk("ack seen", 8'h01, {7'h00, ack});
        stretch_seen();
      end else begin
        chk("nack seen", 8'h00, {7'h00, ack});
        chk("sda free", 8'h00, {7'h00, sda_oe});
      end
    end
    pulse('{irq_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.stop();
    settle();
    chk("free", 8'h01, {6'h00, st.start_seen, st.stop_seen});
    mode = MODE_FW_MASTER;
    sda_dir = 1'b0;
    settle();
    chk("fw sda", 8'h01, {7'h00, sda_oe});
    sda_dir = 1'b1;
    scl_dir = 1'b0;
    settle();
    chk("fw scl", 8'h02, {6'h00, scl_oe, sda_oe});
    i2c_master_model_inst.set_lines(1'b1, 1'b1);
    settle();
    // Firmware sends a one on SDA and sees it low: arbitration is lost.
    if (sda_in !== 1'b1) begin
      scl_dir = 1'b1;
    end
    settle();
    chk("arb lost", 8'h00, {6'h00, scl_oe, sda_oe});
    i2c_master_model_inst.set_lines(1'b1, 1'b0);
    i2c_master_model_inst.start();
    settle();
    chk("fw start irq", 8'h01, {7'h00, st.port_irq_flag});
    pulse('{irq_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.stop();
    settle();
    chk("fw stop irq", 8'h01, {7'h00, st.port_irq_flag});
    mode = MODE_SLAVE10;
    addr_wdata = 8'hf2;
    pulse('{addr_wr: 1'b1, irq_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.start();
    i2c_master_model_inst.byte_io(8'hf2, 1'b1, rd, ack);
    settle();
    chk("high addr", 8'h0f, {4'h0, ack, scl_oe, st.addr_update_flag,
        st.port_irq_flag});
    addr_wdata = 8'h3c;
    pulse('{addr_wr: 1'b1, buf_rd: 1'b1, irq_clr: 1'b1, default: 1'b0});
    chk("ua free", 8'h00, {6'h00, scl_oe, st.addr_update_flag});
    i2c_master_model_inst.byte_io(8'h3c, 1'b1, rd, ack);
    settle();
    chk("low addr", 8'h0f, {4'h0, ack, scl_oe, st.addr_update_flag,
        st.port_irq_flag});
    addr_wdata = 8'hf2;
    pulse('{addr_wr: 1'b1, buf_rd: 1'b1, irq_clr: 1'b1, default: 1'b0});
    i2c_master_model_inst.stop();
    en = 1'b0;
    settle();
    chk("disabled", 8'h00, {6'h00, st.start_seen, st.stop_seen});
    print_verdict();
  end
endmodule
